// ### verilog/timer_counter_pwm_unit_pkg.sv
// constants and types shared by the timer/counter/pwm block
// assumes one clock domain and plain-port configuration
package timer_counter_pwm_pkg;
   localparam int CNT_WIDTH      = 16;
   localparam int UNIT_COUNT     = 8;
   localparam int COMPARE_COUNT  = 2;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] CAPTURE_RESET = 16'h0000;
   localparam logic [1:0]  QUAD_RESET    = 2'h0;

   // counting modes of one unit
   typedef enum logic [2:0] {
      MODE_IDLE    = 3'b001,
      MODE_TIMER   = 3'b010,
      MODE_QUAD    = 3'b100
   } mode_type;

   // quadrature direction from old and new phase pairs
   function automatic logic [1:0] quad_step(input logic [1:0] old_ab,
                                            input logic [1:0] new_ab);
      // bit1: valid step, bit0: up
      logic [3:0] key;
      key = {old_ab, new_ab};
      unique case (key)
         4'h2, 4'hB, 4'hD, 4'h4: quad_step = 2'h3;
         4'h1, 4'h7, 4'hE, 4'h8: quad_step = 2'h2;
         default:                quad_step = 2'h0;
      endcase
   endfunction
endpackage

// ### verilog/deadband_gen.sv
// dead-band generator: true and complementary output from one pwm line
// assumes the pwm input is registered in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module deadband_gen
   import timer_counter_pwm_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // control
   input  wire logic [WIDTH-1:0] dead_time,
   input  wire logic             pwm_in,
   // outputs
   output logic                  out_true,
   output logic                  out_comp
);
   // refuse delay widths the countdown cannot serve
   if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
      $error("deadband width out of range");
   end

   logic             last_reg, last_next;
   logic [WIDTH-1:0] delay_reg, delay_next;
   logic             true_reg, true_next;
   logic             comp_reg, comp_next;

   // edges restart the delay; the rising side waits it out
   always_comb begin
      last_next  = pwm_in;
      delay_next = delay_reg;
      true_next  = true_reg;
      comp_next  = comp_reg;
      if (pwm_in != last_reg) begin
         delay_next = dead_time;
         true_next  = 1'b0;
         comp_next  = 1'b0;
      end else if (delay_reg != '0) begin
         delay_next = delay_reg - 1'b1;
      end else begin
         true_next = pwm_in;
         comp_next = ~pwm_in;
      end
   end

   // state registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         last_reg  <= 1'b0;
         delay_reg <= '0;
         true_reg  <= 1'b0;
         comp_reg  <= 1'b0;
      end else begin
         last_reg  <= last_next;
         delay_reg <= delay_next;
         true_reg  <= true_next;
         comp_reg  <= comp_next;
      end
   end

   assign out_true = true_reg;
   assign out_comp = comp_reg;
endmodule // deadband_gen
`default_nettype wire

// ### verilog/timer_counter_pwm_unit_array.sv
// eight timer/counter/pwm units with plain-port configuration
// assumes all inputs synchronous to clock; kill acts combinationally
// Overview of operation
// - each unit has a 16-bit counter whose period is set by software.
// - a capture event copies the count into a readable capture register.
// - at count equal to period the unit stops or reloads, as configured.
// - compare0 against the count gives the pwm duty output; compare1 gives match1.
// - each unit drives a true output and its complement.
// - kill forces the outputs to a safe level at once, no software needed.
// - a quadrature mode runs the counter from encoder phases a and b.
// - there are eight independent units with their own resources.
`timescale 1ns/1ps
`default_nettype none
module timer_counter_pwm_unit
   import timer_counter_pwm_pkg::*;
#(
   parameter int UNITS    = UNIT_COUNT,
   parameter int DT_WIDTH = 8
) (
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   // per-unit configuration
   input  wire logic [UNITS-1:0]           run_enable,
   input  wire logic [UNITS-1:0]           quad_mode,
   input  wire logic [UNITS-1:0]           one_shot,
   input  wire logic [UNITS*16-1:0]        period,
   input  wire logic [UNITS*16-1:0]        compare0,
   input  wire logic [UNITS*16-1:0]        compare1,
   input  wire logic [UNITS*DT_WIDTH-1:0]  dead_time,
   input  wire logic [UNITS-1:0]           kill_level_true,
   input  wire logic [UNITS-1:0]           kill_level_comp,
   // pins
   input  wire logic [UNITS-1:0]           capture_in,
   input  wire logic [UNITS-1:0]           phase_a,
   input  wire logic [UNITS-1:0]           phase_b,
   input  wire logic                       kill,
   // status and outputs
   output logic [UNITS*16-1:0]             count,
   output logic [UNITS*16-1:0]             capture,
   output logic [UNITS-1:0]                stopped,
   output logic [UNITS-1:0]                match1,
   output logic [UNITS-1:0]                pwm_true,
   output logic [UNITS-1:0]                pwm_comp
);
   // refuse unit counts the slice indexing cannot serve
   if (UNITS < 1 || UNITS > 16) begin : g_bad_units
      $error("unit count out of range");
   end

   for (genvar u = 0; u < UNITS; u++) begin : unit
      logic [15:0] cnt_reg, cnt_next;
      logic [15:0] cap_reg, cap_next;
      logic        cap_last_reg, cap_last_next;
      logic [1:0]  ab_reg, ab_next;
      logic        stop_reg, stop_next;
      logic        pwm_reg, pwm_next;
      logic        m1_reg, m1_next;
      logic [15:0] per;
      logic [15:0] cmp0;
      logic [15:0] cmp1;
      logic [1:0]  step;
      logic        dt_true, dt_comp;
      mode_type    mode;

      assign per  = period[u*16 +: 16];
      assign cmp0 = compare0[u*16 +: 16];
      assign cmp1 = compare1[u*16 +: 16];
      assign step = quad_step(ab_reg, {phase_a[u], phase_b[u]});

      // mode selection
      always_comb begin
         if (!run_enable[u])
            mode = MODE_IDLE;
         else if (quad_mode[u])
            mode = MODE_QUAD;
         else
            mode = MODE_TIMER;
      end

      // counter, capture and compare next values
      always_comb begin
         cnt_next      = cnt_reg;
         stop_next     = stop_reg;
         cap_next      = cap_reg;
         cap_last_next = capture_in[u];
         ab_next       = {phase_a[u], phase_b[u]};
         unique case (mode)
            MODE_IDLE: begin
               stop_next = 1'b0;
            end
            MODE_TIMER: begin
               if (cnt_reg == per) begin
                  if (one_shot[u])
                     stop_next = 1'b1;
                  else
                     cnt_next = COUNT_RESET;
               end else if (!stop_reg) begin
                  cnt_next = cnt_reg + 16'h0001;
               end
            end
            MODE_QUAD: begin
               if (step[1]) begin
                  if (step[0])
                     cnt_next = (cnt_reg == per) ? COUNT_RESET
                                                 : cnt_reg + 16'h0001;
                  else
                     cnt_next = (cnt_reg == 16'h0000) ? per
                                                      : cnt_reg - 16'h0001;
               end
            end
         endcase
         if (capture_in[u] && !cap_last_reg)
            cap_next = cnt_reg;
         pwm_next = (cnt_reg < cmp0);
         m1_next  = (cnt_reg == cmp1);
      end

      // state registers
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            cnt_reg      <= COUNT_RESET;
            cap_reg      <= CAPTURE_RESET;
            cap_last_reg <= 1'b0;
            ab_reg       <= QUAD_RESET;
            stop_reg     <= 1'b0;
            pwm_reg      <= 1'b0;
            m1_reg       <= 1'b0;
         end else begin
            cnt_reg      <= cnt_next;
            cap_reg      <= cap_next;
            cap_last_reg <= cap_last_next;
            ab_reg       <= ab_next;
            stop_reg     <= stop_next;
            pwm_reg      <= pwm_next;
            m1_reg       <= m1_next;
         end
      end

      deadband_gen #(
         .WIDTH(DT_WIDTH)
      ) u_dead (
         .clock    (clock),
         .rst_n    (rst_n),
         .dead_time(dead_time[u*DT_WIDTH +: DT_WIDTH]),
         .pwm_in   (pwm_reg),
         .out_true (dt_true),
         .out_comp (dt_comp)
      );

      // kill overrides without a clock edge
      assign pwm_true[u] = kill ? kill_level_true[u] : dt_true;
      assign pwm_comp[u] = kill ? kill_level_comp[u] : dt_comp;
      assign count[u*16 +: 16]   = cnt_reg;
      assign capture[u*16 +: 16] = cap_reg;
      assign stopped[u]          = stop_reg;
      assign match1[u]           = m1_reg;
   end
endmodule // timer_counter_pwm_unit
`default_nettype wire

// ### verif/timer_counter_pwm_chk.sv
// checker: port relations of the timer array, unit 0 and kill path
// assumes it is bound into timer_counter_pwm_unit and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module timer_counter_pwm_chk
   import timer_counter_pwm_pkg::*;
#(
   parameter int UNITS    = 8,
   parameter int DT_WIDTH = 8
) (
   // clock and reset
   input wire logic                      clock,
   input wire logic                      rst_n,
   // configuration and pins
   input wire logic [UNITS-1:0]          run_enable,
   input wire logic [UNITS-1:0]          quad_mode,
   input wire logic [UNITS-1:0]          one_shot,
   input wire logic [UNITS*16-1:0]       period,
   input wire logic [UNITS*16-1:0]       compare1,
   input wire logic [UNITS*DT_WIDTH-1:0] dead_time,
   input wire logic [UNITS-1:0]          kill_level_true,
   input wire logic [UNITS-1:0]          kill_level_comp,
   input wire logic [UNITS-1:0]          capture_in,
   input wire logic                      kill,
   // outputs
   input wire logic [UNITS*16-1:0]       count,
   input wire logic [UNITS*16-1:0]       capture,
   input wire logic [UNITS-1:0]          stopped,
   input wire logic [UNITS-1:0]          match1,
   input wire logic [UNITS-1:0]          pwm_true,
   input wire logic [UNITS-1:0]          pwm_comp
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // unit 0 views
   wire [15:0] c0 = count[15:0];
   wire [15:0] p0 = period[15:0];
   wire        tm = run_enable[0] & ~quad_mode[0];
   logic [8:0] low_run;
   // cycles both outputs of unit 0 have stayed low
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) low_run <= 9'h000;
      else if (pwm_true[0] | pwm_comp[0]) low_run <= 9'h000;
      else if (low_run != 9'h1FF) low_run <= low_run + 9'h001;
   end
   sequence s_calm; !kill [*8]; endsequence
   sequence s_rise; $rose(pwm_true[0]) || $rose(pwm_comp[0]); endsequence
   a_step_up: assert property (tm & ~stopped[0] & c0 != p0
      |=> c0 == $past(c0) + 16'h0001) else $error("count did not step");
   a_reload_zero: assert property (tm & ~stopped[0] & ~one_shot[0]
      & c0 == p0 |=> c0 == 16'h0000) else $error("no reload to zero");
   a_halt_hold: assert property (tm & one_shot[0] & c0 == p0
      |=> stopped[0] && c0 == $past(c0)) else $error("no halt at period");
   a_capture_copy: assert property ($rose(capture_in[0])
      |=> capture[15:0] == $past(c0)) else $error("capture value wrong");
   a_match_late: assert property (1'b1
      |=> match1[0] == $past(c0 == compare1[15:0])) else $error("match1 wrong");
   a_kill_levels: assert property (kill |-> pwm_true == kill_level_true
      && pwm_comp == kill_level_comp) else $error("kill levels not shown");
   a_no_overlap: assert property (!kill
      |-> (pwm_true & pwm_comp) == '0) else $error("outputs overlap");
   a_dead_gap: assert property (s_calm ##0 s_rise
      |-> low_run >= dead_time[7:0]) else $error("dead band too short");
endmodule // timer_counter_pwm_chk
bind timer_counter_pwm_unit timer_counter_pwm_chk #(.UNITS(UNITS),
   .DT_WIDTH(DT_WIDTH))
   chk_i (.*);
`default_nettype wire

// ### verif/pin_model.sv
// encoder phase and capture event pins seen by the timer array
// assumes the bench calls its tasks from one process only
`timescale 1ns/1ps
`default_nettype none
module pin_model (
   // clock
   input  wire logic clock,
   // pins toward the timer array
   output logic      phase_a,
   output logic      phase_b,
   output logic      event_pin
);
   logic [1:0] pos = 2'h0;
   // quarter position to gray phase pair, a leads when counting up
   assign phase_a = pos[1] ^ pos[0];
   assign phase_b = pos[1];
   initial event_pin = 1'b0;
   // one encoder step, held three edges
   task automatic step(input logic up);
      @(negedge clock);
      pos = up ? pos + 2'h1 : pos - 2'h1;
      repeat (3) @(posedge clock);
   endtask
   // one-cycle event pulse
   task automatic pulse();
      @(negedge clock);
      event_pin = 1'b1;
      @(negedge clock);
      event_pin = 1'b0;
   endtask
endmodule // pin_model
`default_nettype wire

// ### verif/timer_counter_pwm_unit_tb_top.sv
// self-checking bench for the eight-unit timer array
// assumes pin_model drives encoder and capture pins of all units
`timescale 1ns/1ps
`default_nettype none
module timer_counter_pwm_unit_tb_top;
   import timer_counter_pwm_pkg::*;
   typedef struct {int sel; logic [15:0] v;} note_type;
   logic         clock = 1'b0, rst_n = 1'b0, kill = 1'b0;
   logic [7:0]   run_e = '0, quad = '0, one = '0, klt, klc, st, m1, pt, pc;
   logic [127:0] period, compare0, compare1, count, capture;
   logic [63:0]  dead_time;
   wire          ph_a, ph_b, ev;
   wire [287:0]  obs = {m1, st, pt, pc, capture, count};
   int           n_fail = 0, check_count = 0;
   note_type     q [$];
   event         look;
   always #12.5 clock = ~clock;
   timer_counter_pwm_unit timer_counter_pwm_unit_i (.clock(clock), .rst_n(rst_n),
      .run_enable(run_e), .quad_mode(quad), .one_shot(one), .period(period),
      .compare0(compare0), .compare1(compare1), .dead_time(dead_time),
      .kill_level_true(klt), .kill_level_comp(klc), .capture_in({8{ev}}),
      .phase_a({8{ph_a}}), .phase_b({8{ph_b}}), .kill(kill), .count(count),
      .capture(capture), .stopped(st), .match1(m1), .pwm_true(pt),
      .pwm_comp(pc));
   pin_model pin_model_i (.clock(clock), .phase_a(ph_a), .phase_b(ph_b),
      .event_pin(ev));
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   // note an expected slice value for the monitor
   task automatic chk(input int sel, input logic [15:0] v);
      #0.5;
      q.push_back('{sel, v});
      -> look;
   endtask
   // monitor: oldest note against the output slice it names
   always @(look) begin
      note_type n;
      n = q.pop_front();
      check_count++;
      if (obs[n.sel*16 +: 16] !== n.v) begin
         n_fail++;
         $display("mismatch t=%0t got %h exp %h", $time,
            obs[n.sel*16 +: 16], n.v);
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // watchdog
   initial begin
      #75000;
      n_fail++;
      results();
   end
   // main sequence
   initial begin
      void'($urandom(66917));
      for (int u = 0; u < 8; u++) begin
         period[u*16 +: 16] = 16'(2 + $urandom % 19);
         compare0[u*16 +: 16] = 16'($urandom % 20);
         compare1[u*16 +: 16] = 16'($urandom % 20);
         dead_time[u*8 +: 8] = 8'(1 + $urandom % 7);
      end
      klt = 8'($urandom);
      klc = 8'($urandom);
      cyc(2);
      rst_n = 1'b1;
      run_e = 8'hFF;
      cyc(40);
      run_e = 8'h00;
      pin_model_i.pulse();
      cyc(2);
      for (int u = 0; u < 8; u++) begin
         chk(u, 16'(40 % (period[u*16 +: 16] + 1)));
         chk(8 + u, 16'(40 % (period[u*16 +: 16] + 1)));
      end
      $display("test reload and capture done");
      one = 8'hFF;
      run_e = 8'hFF;
      compare1 = period;
      cyc(30);
      for (int u = 0; u < 8; u++) chk(u, period[u*16 +: 16]);
      chk(17, 16'hFFFF);
      cyc(1);
      one = 8'h00;
      run_e = 8'h00;
      kill = 1'b1;
      cyc(2);
      chk(16, {klt, klc});
      cyc(1);
      kill = 1'b0;
      $display("test halt and kill done");
      run_e = 8'hFF;
      cyc(100);
      compare0 = '1;
      cyc(30);
      chk(16, 16'hFF00);
      compare0 = '0;
      cyc(30);
      chk(16, 16'h00FF);
      $display("test duty extremes done");
      rst_n = 1'b0;
      cyc(1);
      rst_n = 1'b1;
      quad = 8'hFF;
      repeat (5) pin_model_i.step(1'b1);
      repeat (7) pin_model_i.step(1'b0);
      cyc(3);
      for (int u = 0; u < 8; u++) chk(u, period[u*16 +: 16] - 16'h0001);
      $display("test quadrature done");
      cyc(1);
      results();
   end
endmodule // timer_counter_pwm_unit_tb_top
`default_nettype wire
